// ---- hdl/accel_params.svh ----
// Constants for the accelerometer measurement and level-detection core.
// Assumes a 20 MHz core clock and a byte-wide register port driven by the host bridge.
`ifndef ACCEL_PARAMS_SVH
`define ACCEL_PARAMS_SVH
// Register offsets
`define ADDR_X10_LO 6'h00
`define ADDR_Z10_HI 6'h05
`define ADDR_X8 6'h06
`define ADDR_Y8 6'h07
`define ADDR_Z8 6'h08
`define ADDR_STATUS 6'h09
`define ADDR_DET_SRC 6'h0A
`define ADDR_MODE 6'h16
`define ADDR_IRQ_CLEAR 6'h17
`define ADDR_CTRL1 6'h18
`define ADDR_CTRL2 6'h19
`define ADDR_LIMIT 6'h1A
// Field positions
`define CTRL1_BW_BIT 7
`define CTRL1_SIGN_BIT 6
`define CTRL1_OFF_LSB 3
`define CTRL1_ROUTE_LSB 1
`define CTRL1_SWAP_BIT 0
`define CTRL2_LEVEL_AND_BIT 0
`define CTRL2_USED_MASK 8'h07
`define MODE_USED_MASK 8'h7F
`define STAT_READY_BIT 0
`define STAT_OVERRUN_BIT 1
`define SRC_LEVEL_BIT 0
`define SRC_AXIS_LSB 1
`define CLEAR_A_BIT 0
`define CLEAR_B_BIT 1
// Reset values
`define RST_CTRL1 8'h00
`define RST_CTRL2 8'h00
`define RST_LIMIT 8'h00
`define RST_MODE 8'h00
// Timing
`define CLK_HZ 20000000
`define RATE_SLOW_HZ 125
`define RATE_FAST_HZ 250
`endif

// ---- hdl/accel_pkg.sv ----
// Types shared by the accelerometer core and its helpers.
// Assumes the constants header is compiled alongside.
package accel_pkg;
   // Operating mode field
   typedef enum logic [1:0] {
      MODE_STANDBY = 2'b00,
      MODE_MEASURE = 2'b01,
      MODE_LEVEL = 2'b10,
      MODE_PULSE = 2'b11
   } op_mode_t;
   // Output range field
   typedef enum logic [1:0] {
      RANGE_8G = 2'b00,
      RANGE_2G = 2'b01,
      RANGE_4G = 2'b10
   } range_t;
   // Raw converter words, 64 counts per g
   typedef struct packed {
      logic [9:0] x;
      logic [9:0] y;
      logic [9:0] z;
   } axes10_t;
   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
      logic [7:0] z;
   } axes8_t;
   typedef struct packed {
      logic event_hit;
      logic [2:0] axis_hit;
   } level_result_t;
   typedef struct packed {
      logic [17:0] count;
      logic tick;
   } timer_state_t;
   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] limit;
      logic [7:0] mode_ctrl;
      axes10_t raw;
      axes8_t out8;
      logic ready;
      logic overrun;
      logic irq_a;
      logic irq_b;
      logic [3:0] src;
      logic [7:0] rdata;
   } core_state_t;
endpackage

// ---- hdl/sample_timer.sv ----
// Sample pacing counter: one tick per conversion period.
// Assumes the period input is stable while running.
`timescale 1ns/1ps
module sample_timer
   import accel_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Control
   input wire logic i_run,
   input wire logic [17:0] i_period,
   // Tick
   output logic o_tick
);
   timer_state_t s;
   timer_state_t next_s;

   // Count to period minus one, then tick and wrap
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!i_run) begin
         next_s.count = 18'h00000;
      end else if (s.count >= i_period - 18'h00001) begin
         next_s.count = 18'h00000;
         next_s.tick = 1'b1;
      end else begin
         next_s.count = s.count + 18'h00001;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_tick = s.tick;
endmodule

// ---- hdl/level_compare.sv ----
// Per-axis threshold comparison for level detection.
// Assumes 8g-scale samples, 16 counts per g, two's complement.
`timescale 1ns/1ps
module level_compare
   import accel_pkg::*;
(
   // Sample and settings
   input wire axes8_t i_sample,
   input wire logic [7:0] i_limit,
   input wire logic i_sign_mode,
   input wire logic i_and_mode,
   input wire logic [2:0] i_axis_off,
   // Result
   output level_result_t o_result
);
   logic [2:0][7:0] vals;
   logic [2:0] above;
   logic [2:0] below;
   logic [2:0] on;

   assign vals = {i_sample.z, i_sample.y, i_sample.x};
   assign on = ~i_axis_off;

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_axis
         logic signed [8:0] cmp;
         logic signed [8:0] thr;
         always_comb begin
            if (i_sign_mode) begin
               cmp = {vals[i][7], vals[i]};
               thr = {i_limit[7], i_limit};
            end else begin
               cmp = vals[i][7] ? 9'(-$signed({vals[i][7], vals[i]})) : {1'b0, vals[i]};
               thr = {2'b00, i_limit[6:0]};
            end
         end
         assign above[i] = cmp > thr;
         assign below[i] = cmp < thr;
      end
   endgenerate

   always_comb begin
      if (i_and_mode) begin
         o_result.axis_hit = below & on;
         o_result.event_hit = (&(below | i_axis_off)) && (|on);
      end else begin
         o_result.axis_hit = above & on;
         o_result.event_hit = |(above & on);
      end
   end
endmodule

// ---- hdl/accel_measure_level_detect.sv ----
// Measurement capture, data-ready and overrun status, and level detection
// with latched, routable interrupt lines, behind a byte register port.
// Assumes the converter presents settled 10-bit axis words, 64 counts per g,
// and the host bridge gives single-cycle read and write strobes.
`timescale 1ns/1ps
`include "accel_params.svh"
module accel_measure_level_detect
   import accel_pkg::*;
#(
   // Conversion periods in core clocks; shorten for simulation
   parameter int unsigned SLOW_PERIOD = `CLK_HZ / `RATE_SLOW_HZ,
   parameter int unsigned FAST_PERIOD = `CLK_HZ / `RATE_FAST_HZ
)
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Converter words
   input wire axes10_t i_axis_raw,
   // Register port
   input wire logic [5:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // Pins
   output logic o_sample_ready,
   output logic o_irq_line_a,
   output logic o_irq_line_b
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   core_state_t s;
   core_state_t next_s;
   op_mode_t mode;
   range_t range_select;
   logic sampling;
   logic detect_on;
   logic sample_tick;
   logic [17:0] period;
   logic axis_read;
   logic status_read;
   logic clear_wr;
   axes8_t det8;
   axes8_t scaled8;
   level_result_t level_res;
   logic level_to_b;
   logic level_masked;
   logic set_a;
   logic set_b;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Clip a raw word into a signed byte
   function automatic logic [7:0] sat8(input logic [9:0] v);
      logic [7:0] r;
      r = v[7:0];
      if (v[9:7] != 3'b000 && v[9:7] != 3'b111) begin
         r = v[9] ? 8'h80 : 8'h7F;
      end
      return r;
   endfunction

   function automatic logic [7:0] scale8(input logic [9:0] v, input range_t r);
      logic [7:0] o;
      o = v[9:2];
      case (r)
         RANGE_8G: o = v[9:2];
         RANGE_2G: o = sat8(v);
         RANGE_4G: o = sat8({v[9], v[9:1]});
         default: o = v[9:2];
      endcase
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode

   assign mode = op_mode_t'(s.mode_ctrl[1:0]);
   assign range_select = range_t'(s.mode_ctrl[3:2]);
   // Standby keeps the converter idle; registers stay reachable
   assign sampling = (mode != MODE_STANDBY);
   assign detect_on = (mode == MODE_LEVEL) || (mode == MODE_PULSE);

   ////////////////////////////////////////////////////////////////////////////
   // Sample pacing

   assign period = s.ctrl1[`CTRL1_BW_BIT] ? 18'(FAST_PERIOD) : 18'(SLOW_PERIOD);

   sample_timer u_timer (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_run(sampling),
      .i_period(period),
      .o_tick(sample_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Level comparison

   assign det8.x = i_axis_raw.x[9:2];
   assign det8.y = i_axis_raw.y[9:2];
   assign det8.z = i_axis_raw.z[9:2];

   assign scaled8.x = scale8(i_axis_raw.x, range_select);
   assign scaled8.y = scale8(i_axis_raw.y, range_select);
   assign scaled8.z = scale8(i_axis_raw.z, range_select);

   level_compare u_compare (
      .i_sample(det8),
      .i_limit(s.limit),
      .i_sign_mode(s.ctrl1[`CTRL1_SIGN_BIT]),
      .i_and_mode(s.ctrl2[`CTRL2_LEVEL_AND_BIT]),
      .i_axis_off(s.ctrl1[`CTRL1_OFF_LSB +: 3]),
      .o_result(level_res)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Strobe decode

   assign axis_read = i_reg_rd && (i_reg_addr <= `ADDR_Z8);
   assign status_read = i_reg_rd && (i_reg_addr == `ADDR_STATUS);
   assign clear_wr = i_reg_wr && (i_reg_addr == `ADDR_IRQ_CLEAR);

   // interrupt routing
   // Routing 11 is left for the pulse engine, so level stays off the pins
   assign level_to_b = (s.ctrl1[`CTRL1_ROUTE_LSB +: 2] == 2'b10) ^ s.ctrl1[`CTRL1_SWAP_BIT];
   // pulse engine absent; its routing code stays reserved
   assign level_masked = (s.ctrl1[`CTRL1_ROUTE_LSB +: 2] == 2'b11);

   assign set_a = sample_tick && detect_on && level_res.event_hit && !level_masked && !level_to_b;
   assign set_b = sample_tick && detect_on && level_res.event_hit && !level_masked && level_to_b;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s = s;

      // Register writes
      if (i_reg_wr) begin
         case (i_reg_addr)
            `ADDR_MODE: next_s.mode_ctrl = i_reg_wdata & `MODE_USED_MASK;
            `ADDR_CTRL1: next_s.ctrl1 = i_reg_wdata;
            `ADDR_CTRL2: next_s.ctrl2 = i_reg_wdata & `CTRL2_USED_MASK;
            `ADDR_LIMIT: next_s.limit = i_reg_wdata;
            default: next_s.ctrl1 = s.ctrl1;
         endcase
      end

      // Ready drops on an axis read
      if (axis_read) begin
         next_s.ready = 1'b0;
      end
      // Overrun clears on a status read
      if (status_read) begin
         next_s.overrun = 1'b0;
      end

      if (sample_tick) begin
         next_s.raw = i_axis_raw;
         next_s.out8 = scaled8;
         next_s.ready = 1'b1;
         if (s.ready && !axis_read) begin
            next_s.overrun = 1'b1;
         end
      end

      // Host clear of the latched lines
      if (clear_wr) begin
         if (i_reg_wdata[`CLEAR_A_BIT]) begin
            next_s.irq_a = 1'b0;
         end
         if (i_reg_wdata[`CLEAR_B_BIT]) begin
            next_s.irq_b = 1'b0;
         end
         next_s.src = 4'h0;
      end

      // latch until cleared
      // A fresh event beats a clear in the same cycle
      if (set_a) begin
         next_s.irq_a = 1'b1;
      end
      if (set_b) begin
         next_s.irq_b = 1'b1;
      end
      if (set_a || set_b) begin
         next_s.src[`SRC_LEVEL_BIT] = 1'b1;
         // Base is the post-clear value, so a same-cycle clear drops stale axes
         next_s.src[`SRC_AXIS_LSB +: 3] = next_s.src[`SRC_AXIS_LSB +: 3] | level_res.axis_hit;
      end

      // Registered read data; unmapped offsets read zero
      if (i_reg_rd) begin
         case (i_reg_addr)
            6'h00: next_s.rdata = s.raw.x[7:0];
            6'h01: next_s.rdata = {6'h00, s.raw.x[9:8]};
            6'h02: next_s.rdata = s.raw.y[7:0];
            6'h03: next_s.rdata = {6'h00, s.raw.y[9:8]};
            6'h04: next_s.rdata = s.raw.z[7:0];
            `ADDR_Z10_HI: next_s.rdata = {6'h00, s.raw.z[9:8]};
            `ADDR_X8: next_s.rdata = s.out8.x;
            `ADDR_Y8: next_s.rdata = s.out8.y;
            `ADDR_Z8: next_s.rdata = s.out8.z;
            `ADDR_STATUS: next_s.rdata = {6'h00, s.overrun, s.ready};
            `ADDR_DET_SRC: next_s.rdata = {4'h0, s.src};
            `ADDR_MODE: next_s.rdata = s.mode_ctrl;
            `ADDR_CTRL1: next_s.rdata = s.ctrl1;
            `ADDR_CTRL2: next_s.rdata = s.ctrl2;
            `ADDR_LIMIT: next_s.rdata = s.limit;
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         s <= '0;
         s.ctrl1 <= `RST_CTRL1;
         s.ctrl2 <= `RST_CTRL2;
         s.limit <= `RST_LIMIT;
         s.mode_ctrl <= `RST_MODE;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register
   assign o_reg_rdata = s.rdata;
   // Pin and status bit share one flop so they never disagree
   assign o_sample_ready = s.ready;
   assign o_irq_line_a = s.irq_a;
   assign o_irq_line_b = s.irq_b;

endmodule

// ---- verif/accel_mld_sva.sv ----
// Checker for the register port, ready pin and interrupt lines.
// Sees only top ports; mode and control one are shadowed from writes.
`timescale 1ns/1ps
module accel_mld_sva (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Register port and pins
   input wire logic [5:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_sample_ready,
   input wire logic o_irq_line_a,
   input wire logic o_irq_line_b
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   logic [7:0] mode_q;
   logic [7:0] ctrl1_q;
   logic axis_rd;
   assign axis_rd = i_reg_rd && i_reg_addr <= 6'h08;
   // Shadow settings, so reads can be judged without the bodies
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         mode_q <= 8'h00;
         ctrl1_q <= 8'h00;
      end else begin
         if (i_reg_wr && i_reg_addr == 6'h16) mode_q <= i_reg_wdata;
         if (i_reg_wr && i_reg_addr == 6'h18) ctrl1_q <= i_reg_wdata;
      end
   end
   sequence s_stat_rd;
      i_reg_rd && i_reg_addr == 6'h09;
   endsequence
   sequence s_ctrl1_rd;
      i_reg_rd && i_reg_addr == 6'h18;
   endsequence
   a_ready_hold: assert property (o_sample_ready && !axis_rd |=> o_sample_ready)
      else $error("ready dropped without axis read");
   a_ready_drop: assert property ($fell(o_sample_ready) && !$past(i_sys_rst)
      |-> $past(axis_rd)) else $error("ready fell with no cause");
   a_irq_a_hold: assert property (o_irq_line_a && !(i_reg_wr && i_reg_addr == 6'h17
      && i_reg_wdata[0]) |=> o_irq_line_a) else $error("line a dropped");
   a_irq_b_hold: assert property (o_irq_line_b && !(i_reg_wr && i_reg_addr == 6'h17
      && i_reg_wdata[1]) |=> o_irq_line_b) else $error("line b dropped");
   // The line rises one edge after the mode that judged it was in force
   a_irq_mode_only: assert property ($rose(o_irq_line_a || o_irq_line_b)
      |-> $past(mode_q[1])) else $error("interrupt outside detect modes");
   // Tick flop then state flop: the launching mode is two samples back
   a_ready_awake: assert property ($rose(o_sample_ready)
      |-> $past(mode_q[1:0], 2) != 2'b00) else $error("sample in standby");
   a_status_read: assert property (s_stat_rd |=> o_reg_rdata[7:2] == 6'h00
      && o_reg_rdata[0] == $past(o_sample_ready)) else $error("status bad");
   a_ctrl1_read: assert property (s_ctrl1_rd |=> o_reg_rdata == $past(ctrl1_q))
      else $error("control one readback");
   a_rdata_hold: assert property ($past(!i_reg_rd && !i_sys_rst)
      |-> $stable(o_reg_rdata)) else $error("read data moved");
endmodule
bind accel_measure_level_detect accel_mld_sva i_accel_mld_sva (.i_mclk, .i_sys_rst,
   .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_sample_ready,
   .o_irq_line_a, .o_irq_line_b);

// ---- verif/accel_host_model.sv ----
// Host side of the register port: one-cycle strobes set at falling edges.
// Assumes read data is valid the cycle after the read strobe.
`timescale 1ns/1ps
module accel_host_model (
   // Clock
   input wire logic i_mclk,
   // Register port
   output logic [5:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   input wire logic [7:0] i_rdata
);
   initial begin
      o_addr = 6'h3F;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // Data inverted after the strobe so stale values never look valid
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(negedge i_mclk);
      o_addr = a;
      o_wdata = v;
      o_wr = 1'b1;
      @(negedge i_mclk);
      o_wr = 1'b0;
      o_wdata = ~v;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(negedge i_mclk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_mclk);
      o_rd = 1'b0;
      v = i_rdata;
   endtask
endmodule

// ---- verif/accel_measure_level_detect_tb.sv ----
// Self-checking bench: measurement, overrun, ranges and level detection.
// Assumes shortened conversion periods; inputs change at falling edges.
`timescale 1ns/1ps
module accel_measure_level_detect_tb;
   import accel_pkg::*;
   localparam int SLOW = 20;
   localparam int FAST = 10;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   axes10_t raw = '0;
   logic [5:0] addr;
   logic [7:0] wdata, rdata, d, c1, c2, lim, md;
   logic wr, rd, rdy, irqa, irqb, ea, eb;
   logic [31:0] seed = 32'd53250;
   logic [31:0] r;
   logic [3:0] e;
   longint t_rise = 0;
   longint t_prev = 0;
   int n_fail = 0;
   int checks = 0;
   always #25 i_mclk = ~i_mclk;
   always @(posedge rdy) begin
      t_prev = t_rise;
      t_rise = $time;
   end
   accel_host_model i_accel_host_model (.i_mclk(i_mclk), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
   accel_measure_level_detect #(.SLOW_PERIOD(SLOW), .FAST_PERIOD(FAST))
      i_accel_measure_level_detect (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_axis_raw(raw), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rdata), .o_sample_ready(rdy), .o_irq_line_a(irqa),
      .o_irq_line_b(irqb));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Byte view: 2g and 4g saturate, other codes give the 8g view
   function automatic logic [7:0] exp8(input logic signed [9:0] v, input logic [1:0] g);
      logic signed [9:0] s;
      s = (g == 2'b10) ? v >>> 1 : v;
      if (g[1] == g[0]) return v[9:2];
      if (s > 10'sh07F) return 8'h7F;
      if (s < 10'sh380) return 8'h80;
      return s[7:0];
   endfunction
   // Returns above-limit axes and the event bit, on the 8g view of each axis
   function automatic logic [3:0] lvl(input axes10_t a);
      logic [9:0] w [3];
      logic [2:0] gt, lt, en;
      logic signed [8:0] v, t;
      w = '{a.x, a.y, a.z};
      en = ~c1[5:3];
      t = c1[6] ? {lim[7], lim} : {2'b00, lim[6:0]};
      for (int i = 0; i < 3; i++) begin
         v = {w[i][9], w[i][9:2]};
         if (!c1[6] && v < 9'sh000) v = -v;
         gt[i] = v > t;
         lt[i] = v < t;
      end
      return {gt & en, c2[0] ? (&(lt | ~en) && |en) : |(gt & en)};
   endfunction
   task automatic stop_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [5:0] a, input logic [7:0] v);
      i_accel_host_model.wr(a, v);
   endtask
   task automatic rc(input logic [5:0] a, input logic [7:0] v);
      i_accel_host_model.rd(a, d);
      chk(d, v);
   endtask
   // Bounded wait for a new sample
   task automatic wait_rdy();
      for (int i = 0; i < 200; i++) begin
         @(posedge i_mclk);
         #1;
         if (rdy === 1'b1) return;
      end
      n_fail++;
      $display("CHECK FAILED at %0t: no sample", $time);
      stop_test();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge i_mclk);
      @(negedge i_mclk);
      i_sys_rst = 1'b0;
      rc(6'h18, 8'h00);
      rc(6'h19, 8'h00);
      rc(6'h1A, 8'h00);
      rc(6'h3F, 8'h00);
      w(6'h19, 8'hFF);
      rc(6'h19, 8'h07);
      // Rates, status, byte ranges and 10-bit words; detection must stay off
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         raw = r[29:0];
         w(6'h18, {k[0], 7'h00});
         w(6'h16, {4'h0, k[1:0], 2'b01});
         i_accel_host_model.rd(6'h06, d);
         wait_rdy();
         i_accel_host_model.rd(6'h06, d);
         wait_rdy();
         // A tick at the first read hides a rise, so time two clean rises
         i_accel_host_model.rd(6'h06, d);
         wait_rdy();
         chk({7'h0, t_rise - t_prev == (k[0] ? FAST : SLOW) * 50}, 8'h01);
         rc(6'h09, 8'h01);
         rc(6'h06, exp8(raw.x, k[1:0]));
         chk({7'h0, rdy}, 8'h00);
         rc(6'h07, exp8(raw.y, k[1:0]));
         rc(6'h00, raw.x[7:0]);
         rc(6'h01, {6'h00, raw.x[9:8]});
         chk({6'h00, irqb, irqa}, 8'h00);
      end
      // A second sample lands on unread data
      w(6'h18, 8'h00);
      i_accel_host_model.rd(6'h06, d);
      wait_rdy();
      repeat (SLOW) @(posedge i_mclk);
      rc(6'h09, 8'h03);
      rc(6'h09, 8'h01);
      // Standby: a tick already launched may land, then sampling stops
      w(6'h16, 8'h00);
      i_accel_host_model.rd(6'h06, d);
      repeat (2 * SLOW) @(negedge i_mclk);
      chk({7'h0, rdy}, 8'h00);
      rc(6'h09, 8'h00);
      // Random level settings in level and pulse modes, one hand-made corner
      for (int k = 0; k < 24; k++) begin
         r = rnd();
         raw = r[29:0];
         c1 = r[7:0];
         c2 = {5'h00, r[10:8]};
         lim = r[19:12];
         if (k == 0) begin
            raw.x = 10'h200;
            lim = 8'h7F;
            c1 = 8'h00;
            c2 = 8'h00;
         end
         // Host keeps the top limit bit clear in magnitude mode
         if (!c1[6]) lim[7] = 1'b0;
         md = {4'h0, r[21:20], 1'b1, k[0]};
         w(6'h18, c1);
         w(6'h19, c2);
         w(6'h1A, lim);
         w(6'h16, md);
         w(6'h17, 8'h03);
         i_accel_host_model.rd(6'h06, d);
         wait_rdy();
         e = lvl(raw);
         ea = e[0] && c1[2:1] != 2'b11 && !(c1[2] ^ c1[0]);
         eb = e[0] && c1[2:1] != 2'b11 && (c1[2] ^ c1[0]);
         chk({6'h00, irqb, irqa}, {6'h00, eb, ea});
         i_accel_host_model.rd(6'h0A, d);
         // Cause is only recorded when the event reaches a line
         chk(d & (c2[0] ? 8'h01 : 8'h0F),
            {4'h0, e} & {8{ea | eb}} & (c2[0] ? 8'h01 : 8'h0F));
         rc(6'h08, exp8(raw.z, md[3:2]));
         rc(6'h1A, lim);
      end
      // Reset in mid-run clears pins and settings
      @(negedge i_mclk);
      i_sys_rst = 1'b1;
      repeat (6) @(negedge i_mclk);
      i_sys_rst = 1'b0;
      chk({5'h00, rdy, irqb, irqa}, 8'h00);
      rc(6'h16, 8'h00);
      stop_test();
   end
endmodule
